// File: pkg/rpf_pkg.sv
// Package holding constants, register map and types for the radio FIFO control.
package rpf_pkg;
    localparam int unsigned CLK_HZ        = 100_000_000;
    localparam int unsigned STEP_US       = 250;
    localparam int unsigned STEP_CYC      = (CLK_HZ / 1_000_000) * STEP_US;
    localparam logic [5:0]  OFF_STATUS    = 6'h01;
    localparam logic [5:0]  OFF_TX_LAYOUT = 6'h1e;
    localparam logic [5:0]  OFF_RX_LAYOUT = 6'h1f;
    localparam logic [5:0]  OFF_FLAG_SEL  = 6'h28;
    localparam logic [5:0]  OFF_RETRY     = 6'h07;
    localparam logic [5:0]  OFF_RESEND    = 6'h08;
    localparam int unsigned BIT_LAYOUT    = 6;
    localparam int unsigned BIT_TX_FLAG   = 1;
    localparam int unsigned BIT_RX_OCC    = 0;
    localparam logic        TX_FLAG_RST   = 1'b1;
    localparam logic [1:0]  SEL_RST       = 2'h0;
    localparam logic [7:0]  RETRY_RST     = 8'h00;
    localparam int unsigned MAX_BLOCKS    = 6;
    localparam logic [2:0]  BLK3          = 3'h3;
    localparam logic [2:0]  BLK6          = 3'h6;
    localparam logic [5:0]  BSZ32         = 6'h20;
    localparam logic [5:0]  BSZ16         = 6'h10;
    localparam logic [1:0]  SEL_EMPTY     = 2'h0;
    localparam logic [1:0]  SEL_FULL      = 2'h1;
    localparam logic [1:0]  SEL_NOT_EMPTY = 2'h2;
    localparam logic [1:0]  SEL_NOT_FULL  = 2'h3;
    typedef enum logic [4:0] {
        RPF_IDLE    = 5'b00001,
        RPF_AIR     = 5'b00010,
        RPF_ACK     = 5'b00100,
        RPF_WAIT    = 5'b01000,
        RPF_RESEND  = 5'b10000
    } rpf_tx_state_t;
endpackage

// File: pkg/rpf_occ_if.sv
// Interface carrying block occupancy requests and conditions.
`timescale 1ns/1ps
interface rpf_occ_if;
    logic       fill;
    logic       release_one;
    logic       flush;
    logic       six_blocks;
    logic       empty;
    logic       full;
    modport ctl (output fill, release_one, flush, six_blocks,
                 input empty, full);
    modport occ (input fill, release_one, flush, six_blocks,
                 output empty, full);
endinterface

// File: hw/rpf_occ.sv
// Per-block occupancy tracker for one FIFO.
`timescale 1ns/1ps
module rpf_occ
    import rpf_pkg::*;
#(
    parameter int unsigned NBLK = MAX_BLOCKS
) (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rst_n,
    // Occupancy port.
    rpf_occ_if.occ    o
);
    logic [NBLK-1:0] used_r;
    logic [NBLK-1:0] lim;
    logic [NBLK-1:0] wptr_r;
    logic [NBLK-1:0] rptr_r;

    // Only the first three blocks exist in the large-block layout.
    assign lim = o.six_blocks ? {NBLK{1'b1}} : NBLK'(7);

    always_ff @(posedge clk) begin
        if (!rst_n || o.flush) begin
            used_r <= '0;
            wptr_r <= NBLK'(1);
            rptr_r <= NBLK'(1);
        end else begin
            if (o.fill && !o.full) begin // RULE19
                used_r <= (used_r | wptr_r) &
                          ~((o.release_one && !o.empty) ? rptr_r : '0);
                wptr_r <= ((wptr_r << 1) & lim) == '0 ? NBLK'(1)
                          : (wptr_r << 1);
            end else if (o.release_one && !o.empty) begin
                used_r <= used_r & ~rptr_r;
            end
            if (o.release_one && !o.empty) begin
                rptr_r <= ((rptr_r << 1) & lim) == '0 ? NBLK'(1)
                          : (rptr_r << 1);
            end
        end
    end

    assign o.empty = (used_r & lim) == '0; // RULE19
    assign o.full  = (used_r & lim) == lim; // RULE19
endmodule

// File: hw/rpf_ctrl.sv
// Packet FIFO control with automatic acknowledge and resend sequencing.
//
// Behaviour
// RULE1 - Unacknowledged packet: stop listening, wait ack delay plus resend delay, resend. Code scales the resend delay by a multiple cycling 1, 2, 3.
// RULE2 - A packet received with errors gets no acknowledgement.
// RULE3 - Sender raises interrupt only after the acknowledgement arrives.
// RULE4 - New good packet: store in receive FIFO, interrupt, send acknowledgement.
// RULE5 - Repeated packet: acknowledge again but no new interrupt.
// RULE6 - Layout bit 6 per FIFO: three 32-byte or six 16-byte blocks.
// RULE7 - Data payload and acknowledge payload use separate write commands.
// RULE8 - Without resend, a transmit block frees once its data is sent.
// RULE9 - With resend, transmit data stays until acknowledged or retries end.
// RULE10 - Acknowledge payload stays until a new packet arrives on that pipe.
// RULE11 - A write longer than the block size is aborted.
// RULE12 - A write with no free block is aborted.
// RULE13 - Host writes at least one byte in every transmit write.
// RULE14 - Transmit flag bit 1 follows the chosen condition, ignores writes, resets 1.
// RULE15 - Selector: 00 empty, 01 full, 10 not empty, 11 not full.
// RULE16 - Receive occupied bit 0 is set while receive FIFO holds data.
// RULE17 - Ack wait delay is four bits of 250 us steps, zero meaning 250 us.
// RULE18 - A full receive FIFO accepts no further packets.
// RULE19 - Block occupancy and conditions update in the same cycle.
`timescale 1ns/1ps
module rpf_ctrl
    import rpf_pkg::*;
#(
    parameter int unsigned STEP = STEP_CYC
) (
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Register port from the serial command decoder.
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [5:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    // Transmit FIFO write stream.
    input  wire logic       txw_start,
    input  wire logic       txw_ack_payload,
    input  wire logic       txw_retry,
    input  wire logic [2:0] txw_pipe,
    input  wire logic       txw_byte,
    input  wire logic       txw_end,
    output logic            txw_abort,
    input  wire logic       tx_flush,
    // Receive FIFO side.
    input  wire logic       rx_read_done,
    input  wire logic       rx_flush,
    // Baseband events.
    input  wire logic       bb_tx_done,
    input  wire logic       bb_ack_seen,
    input  wire logic       bb_ack_timeout,
    input  wire logic       bb_rx_pkt,
    input  wire logic       bb_rx_crc_ok,
    input  wire logic       bb_rx_repeat,
    input  wire logic [2:0] bb_rx_pipe,
    input  wire logic       bb_ack_payload_en,
    // Baseband requests and interrupt.
    output logic            bb_send_req,
    output logic            bb_send_ack,
    output logic            bb_ack_with_payload,
    output logic            rx_store,
    output logic            irq
);
    import rpf_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic          tx_six_r;
    logic          rx_six_r;
    logic [1:0]    sel_r;
    logic [7:0]    retry_cfg_r;
    logic [3:0]    max_resend_r;
    logic [3:0]    resend_cnt_r;
    logic          tx_flag_r;
    logic          rx_occ_r;
    logic          txw_active_r;
    logic          txw_bad_r;
    logic [5:0]    txw_cnt_r;
    logic          cur_retry_r;
    logic          ack_held_r;
    logic [2:0]    ack_pipe_r;
    logic [1:0]    mult_r;
    logic [7:0]    steps_r;
    logic [31:0]   sub_r;
    rpf_tx_state_t st_r;
    rpf_tx_state_t st_nxt;

    rpf_occ_if txq ();
    rpf_occ_if rxq ();

    rpf_occ #(.NBLK(MAX_BLOCKS)) u_txq (
        .clk   (clk),
        .rst_n (rst_n),
        .o     (txq.occ)
    );
    rpf_occ #(.NBLK(MAX_BLOCKS)) u_rxq (
        .clk   (clk),
        .rst_n (rst_n),
        .o     (rxq.occ)
    );

    function automatic logic [5:0] blk_size(input logic six);
        blk_size = six ? BSZ16 : BSZ32; // RULE6
    endfunction

    function automatic logic cond_of(input logic [1:0] s,
                                     input logic e, input logic f);
        unique case (s) // RULE15
            SEL_EMPTY:     cond_of = e;
            SEL_FULL:      cond_of = f;
            SEL_NOT_EMPTY: cond_of = !e;
            SEL_NOT_FULL:  cond_of = !f;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Register writes.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tx_six_r     <= 1'b0;
            rx_six_r     <= 1'b0;
            sel_r        <= SEL_RST;
            retry_cfg_r  <= RETRY_RST;
            max_resend_r <= RETRY_RST[3:0];
        end else if (reg_wr) begin
            // Layout changes take effect at once; software must flush first.
            if (reg_addr == OFF_TX_LAYOUT) begin
                tx_six_r <= reg_wdata[BIT_LAYOUT]; // RULE6
            end
            if (reg_addr == OFF_RX_LAYOUT) begin
                rx_six_r <= reg_wdata[BIT_LAYOUT]; // RULE6
            end
            if (reg_addr == OFF_FLAG_SEL) begin
                sel_r <= reg_wdata[1:0];
            end
            if (reg_addr == OFF_RETRY) begin
                retry_cfg_r <= reg_wdata;
            end
            if (reg_addr == OFF_RESEND) begin
                max_resend_r <= reg_wdata[7:4];
            end
        end
    end

    // Register reads; the status flags ignore writes.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                OFF_STATUS:    reg_rdata <= {6'h00, tx_flag_r, rx_occ_r};
                OFF_TX_LAYOUT: reg_rdata <= {1'b0, tx_six_r, 6'h00};
                OFF_RX_LAYOUT: reg_rdata <= {1'b0, rx_six_r, 5'h00, rx_occ_r};
                OFF_FLAG_SEL:  reg_rdata <= {6'h00, sel_r};
                OFF_RETRY:     reg_rdata <= retry_cfg_r;
                OFF_RESEND:    reg_rdata <= {max_resend_r, resend_cnt_r};
                default:       reg_rdata <= 8'h00;
            endcase
        end
    end

    // Status flags follow the occupancy conditions.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tx_flag_r <= TX_FLAG_RST; // RULE14
            rx_occ_r  <= 1'b0;
        end else begin
            tx_flag_r <= cond_of(sel_r, txq.empty, txq.full); // RULE14
            rx_occ_r  <= !rxq.empty; // RULE16
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmit FIFO write stream; a block is committed only at the end.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            txw_active_r <= 1'b0;
            txw_bad_r    <= 1'b0;
            txw_cnt_r    <= 6'h00;
            txw_abort    <= 1'b0;
            cur_retry_r  <= 1'b0;
            ack_held_r   <= 1'b0;
            ack_pipe_r   <= 3'h0;
        end else begin
            txw_abort <= 1'b0;
            if (txw_start) begin
                txw_active_r <= 1'b1;
                txw_bad_r    <= txq.full; // RULE12
                txw_abort    <= txq.full; // RULE12
                txw_cnt_r    <= 6'h00;
            end else if (txw_active_r && txw_byte && !txw_bad_r) begin
                if (txw_cnt_r == blk_size(tx_six_r)) begin
                    txw_bad_r <= 1'b1; // RULE11
                    txw_abort <= 1'b1; // RULE11
                end else begin
                    txw_cnt_r <= txw_cnt_r + 6'h01;
                end
            end
            if (bb_ack_with_payload) begin
                ack_held_r <= 1'b0; // RULE10
            end
            if (txw_end) begin
                txw_active_r <= 1'b0;
                // Empty writes are the host's fault and simply dropped.
                if (!txw_bad_r && txw_cnt_r != 6'h00) begin // RULE13
                    if (txw_ack_payload) begin // RULE7
                        ack_held_r <= 1'b1;
                        ack_pipe_r <= txw_pipe;
                    end else begin
                        cur_retry_r <= txw_retry;
                    end
                end
            end
            if (tx_flush) begin
                ack_held_r <= 1'b0; // RULE10
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive side: store, acknowledge and interrupt.
    logic rx_good;
    assign rx_good = bb_rx_pkt && bb_rx_crc_ok && !rxq.full; // RULE18

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rx_store            <= 1'b0;
            bb_send_ack         <= 1'b0;
            bb_ack_with_payload <= 1'b0;
        end else begin
            rx_store    <= rx_good && !bb_rx_repeat; // RULE4
            bb_send_ack <= rx_good; // RULE2 RULE5
            bb_ack_with_payload <= rx_good && bb_ack_payload_en
                                   && ack_held_r && bb_rx_pipe == ack_pipe_r;
        end
    end

    assign rxq.fill        = rx_good && !bb_rx_repeat; // RULE4
    assign rxq.release_one = rx_read_done;
    assign rxq.flush       = rx_flush;
    assign rxq.six_blocks  = rx_six_r;

    ////////////////////////////////////////////////////////////////////////
    // Transmit sequencing.
    logic sent_ok;
    logic give_up;
    logic timer_done;
    assign timer_done = (steps_r == 8'h00) && (sub_r == 32'h0);
    assign give_up    = bb_ack_timeout && (resend_cnt_r >= max_resend_r);
    assign sent_ok    = (st_r == RPF_ACK) && bb_ack_seen;

    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            // A held acknowledge payload is never sent as a data packet.
            RPF_IDLE:   if (!txq.empty && !txw_active_r && !ack_held_r) begin
                            st_nxt = RPF_AIR;
                        end
            RPF_AIR:    if (bb_tx_done) begin
                            st_nxt = cur_retry_r ? RPF_ACK : RPF_IDLE;
                        end
            RPF_ACK:    if (bb_ack_seen || give_up) begin
                            st_nxt = RPF_IDLE;
                        end else if (bb_ack_timeout) begin
                            st_nxt = RPF_WAIT; // RULE1
                        end
            RPF_WAIT:   if (timer_done) st_nxt = RPF_RESEND; // RULE1
            RPF_RESEND: st_nxt = RPF_AIR;
            default:    st_nxt = RPF_IDLE;
        endcase
        if (tx_flush) begin
            st_nxt = RPF_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r <= RPF_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Delay timer: ack wait delay plus resend delay times a multiple cycling 1, 2, 3.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            steps_r      <= 8'h00;
            sub_r        <= 32'h0;
            mult_r       <= 2'h1;
            resend_cnt_r <= 4'h0;
        end else if (st_r == RPF_ACK && bb_ack_timeout && !give_up) begin
            // Zero ack-wait still means one step; resend zero means none.
            steps_r <= 8'(retry_cfg_r[7:4]) + 8'h01 +
                       8'(retry_cfg_r[3:0]) * 8'(mult_r); // RULE17 RULE1
            sub_r   <= 32'(STEP - 1);
            mult_r  <= (mult_r == 2'h3) ? 2'h1 : mult_r + 2'h1;
            resend_cnt_r <= resend_cnt_r + 4'h1;
        end else if (st_r == RPF_WAIT && !timer_done) begin
            if (sub_r == 32'h0) begin
                sub_r   <= 32'(STEP - 1);
                steps_r <= steps_r - 8'h01;
            end else if (sub_r == 32'h1 && steps_r == 8'h01) begin
                sub_r   <= 32'h0;
                steps_r <= 8'h00;
            end else begin
                sub_r <= sub_r - 32'h1;
            end
        end else if (st_r == RPF_IDLE && st_nxt == RPF_AIR) begin
            mult_r       <= 2'h1;
            resend_cnt_r <= 4'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bb_send_req <= 1'b0;
            irq         <= 1'b0;
        end else begin
            bb_send_req <= (st_nxt == RPF_AIR) && (st_r != RPF_AIR);
            irq <= sent_ok || (rx_good && !bb_rx_repeat); // RULE3 RULE4 RULE5
        end
    end

    // Release a transmit block once data is sent, acknowledged or abandoned, or an acknowledge payload is sent.
    assign txq.release_one = (st_r == RPF_AIR && bb_tx_done
                              && !cur_retry_r) // RULE8
                             || sent_ok // RULE9
                             || (st_r == RPF_ACK && give_up) // RULE9
                             || bb_ack_with_payload; // RULE10
    assign txq.fill  = txw_end && txw_active_r && !txw_bad_r
                       && txw_cnt_r != 6'h00; // RULE13
    assign txq.flush = tx_flush;
    assign txq.six_blocks = tx_six_r;
endmodule

// File: tb/rpf_ctrl_props.sv
// Port-level assertions for the packet FIFO control block.
`timescale 1ns/1ps
module rpf_ctrl_props
    import rpf_pkg::*;
#(
    parameter int unsigned STEP = STEP_CYC
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Watched ports.
    input wire logic txw_abort,
    input wire logic bb_ack_seen,
    input wire logic bb_ack_timeout,
    input wire logic bb_rx_pkt,
    input wire logic bb_rx_crc_ok,
    input wire logic bb_rx_repeat,
    input wire logic bb_send_req,
    input wire logic bb_send_ack,
    input wire logic bb_ack_with_payload,
    input wire logic rx_store,
    input wire logic irq
);
    logic        good_w;
    logic        pend_r;
    int unsigned gap_r;
    assign good_w = bb_rx_pkt && bb_rx_crc_ok;
    ////////////////////////////////////////////////////////////////////////
    // A resend may not follow a timeout sooner than one full delay step.
    always_ff @(posedge clk) begin
        if (!rst_n || bb_ack_timeout) begin
            gap_r <= 0;
        end else begin
            gap_r <= gap_r + 1;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n || bb_send_req) begin
            pend_r <= 1'b0;
        end else if (bb_ack_timeout) begin
            pend_r <= 1'b1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_bad_crc_quiet: assert property (bb_rx_pkt && !bb_rx_crc_ok
        |=> !bb_send_ack && !rx_store) else $error("answer to bad packet");
    a_ack_cause: assert property (bb_send_ack |-> $past(good_w))
        else $error("ack without good packet");
    a_store_cause: assert property (rx_store
        |-> $past(good_w) && !$past(bb_rx_repeat)) else $error("bad store");
    a_store_irq: assert property (rx_store |-> irq && bb_send_ack)
        else $error("store without irq and ack");
    a_repeat_silent: assert property (good_w && bb_rx_repeat
        |=> !rx_store && !irq) else $error("repeat packet stored");
    a_irq_cause: assert property (irq
        |-> $past(bb_ack_seen) || rx_store) else $error("irq without cause");
    a_payload_pair: assert property (bb_ack_with_payload
        |-> bb_send_ack) else $error("payload without ack");
    a_abort_pulse: assert property (txw_abort |=> !txw_abort)
        else $error("abort longer than one cycle");
    a_resend_gap: assert property (bb_send_req && pend_r
        |-> gap_r + 1 >= STEP) else $error("resend too early");
endmodule

// File: tb/rpf_peer.sv
// Peer radio model answering transmissions with done, ack or timeout.
`timescale 1ns/1ps
module rpf_peer (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rst_n,
    // Behaviour chosen by the bench.
    input  wire logic stall,
    input  wire logic listen,
    input  wire logic lose_ack,
    // Baseband handshake.
    input  wire logic bb_send_req,
    output logic      bb_tx_done,
    output logic      bb_ack_seen,
    output logic      bb_ack_timeout
);
    logic [1:0] ph_r;
    initial {bb_tx_done, bb_ack_seen, bb_ack_timeout} = 3'h0;
    always @(posedge clk) begin
        bb_tx_done     <= 1'b0;
        bb_ack_seen    <= 1'b0;
        bb_ack_timeout <= 1'b0;
        if (!rst_n) begin
            ph_r <= 2'h0;
        end else if (ph_r == 2'h0 && bb_send_req) begin
            ph_r <= 2'h1;
        end else if (ph_r == 2'h1 && !stall) begin
            // Stretching air time keeps the block occupied on purpose.
            bb_tx_done <= 1'b1;
            ph_r       <= listen ? 2'h2 : 2'h0;
        end else if (ph_r == 2'h2) begin
            bb_ack_timeout <= lose_ack;
            bb_ack_seen    <= !lose_ack;
            ph_r           <= 2'h0;
        end
    end
endmodule

// File: tb/rpf_ctrl_bench.sv
// Self-checking bench for the packet FIFO control block.
`timescale 1ns/1ps
module rpf_ctrl_bench;
    import rpf_pkg::*;
    typedef struct packed {
        logic       w;
        logic [5:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } rpf_row_t;
    localparam rpf_row_t ROWS [16] = '{
        '{1'b0, 6'h01, 8'h00, 8'h02}, '{1'b0, 6'h1e, 8'h00, 8'h00},
        '{1'b0, 6'h1f, 8'h00, 8'h00}, '{1'b0, 6'h28, 8'h00, 8'h00},
        '{1'b1, 6'h01, 8'h00, 8'h00}, '{1'b0, 6'h01, 8'h00, 8'h02},
        '{1'b1, 6'h28, 8'h01, 8'h00}, '{1'b0, 6'h01, 8'h00, 8'h00},
        '{1'b1, 6'h28, 8'h02, 8'h00}, '{1'b0, 6'h01, 8'h00, 8'h00},
        '{1'b1, 6'h28, 8'h03, 8'h00}, '{1'b0, 6'h01, 8'h00, 8'h02},
        '{1'b0, 6'h28, 8'h00, 8'h03}, '{1'b0, 6'h3f, 8'h00, 8'h00},
        '{1'b1, 6'h1e, 8'h40, 8'h00}, '{1'b0, 6'h1e, 8'h00, 8'h40}};
    logic       clk, rst_n, reg_wr, reg_rd, txw_start, txw_ack_payload;
    logic       txw_retry, txw_byte, txw_end, txw_abort, tx_flush, irq;
    logic       rx_read_done, rx_flush, bb_tx_done, bb_ack_seen, rx_store;
    logic       bb_ack_timeout, bb_rx_pkt, bb_rx_crc_ok, bb_rx_repeat;
    logic       bb_ack_payload_en, bb_send_req, bb_send_ack, stall;
    logic       bb_ack_with_payload, listen, lose_ack;
    logic [5:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, q;
    logic [2:0] txw_pipe, bb_rx_pipe;
    int         error_cnt, cmp_count, req_cnt, irq_cnt, ab_cnt, to_cnt;
    int         r0, i0, a0, nb, bs, wt;
    rpf_ctrl #(.STEP(4)) dut_u (
        .clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .txw_start, .txw_ack_payload, .txw_retry, .txw_pipe, .txw_byte,
        .txw_end, .txw_abort, .tx_flush, .rx_read_done, .rx_flush,
        .bb_tx_done, .bb_ack_seen, .bb_ack_timeout, .bb_rx_pkt,
        .bb_rx_crc_ok, .bb_rx_repeat, .bb_rx_pipe, .bb_ack_payload_en,
        .bb_send_req, .bb_send_ack, .bb_ack_with_payload, .rx_store, .irq);
    rpf_peer peer_u (.clk, .rst_n, .stall, .listen, .lose_ack,
        .bb_send_req, .bb_tx_done, .bb_ack_seen, .bb_ack_timeout);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (bb_send_req === 1'b1) req_cnt++;
        if (irq === 1'b1) irq_cnt++;
        if (txw_abort === 1'b1) ab_cnt++;
        if (bb_ack_timeout === 1'b1) to_cnt++;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] g, input logic [7:0] e,
                         input string m);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %0t %s got %h want %h", $time, m, g, e);
        end
    endtask
    task automatic rw(input logic w, input logic [5:0] a,
                      input logic [7:0] d, output logic [7:0] r);
        @(posedge clk);
        reg_wr    <= w;
        reg_rd    <= !w;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1 r = reg_rdata;
    endtask
    task automatic stat(input logic [1:0] s, input logic [7:0] e);
        rw(1'b1, OFF_FLAG_SEL, {6'h00, s}, q);
        rw(1'b0, OFF_STATUS, 8'h00, q);
        check(q, e, "status");
    endtask
    task automatic txw(input int n, input logic ap, input logic rt,
                       input logic [2:0] p);
        @(posedge clk);
        txw_start       <= 1'b1;
        txw_ack_payload <= ap;
        txw_retry       <= rt;
        txw_pipe        <= p;
        @(posedge clk);
        txw_start <= 1'b0;
        txw_byte  <= 1'b1;
        repeat (n) @(posedge clk);
        txw_byte <= 1'b0;
        txw_end  <= 1'b1;
        @(posedge clk);
        txw_end <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic rxp(input logic c, input logic r, input logic [2:0] p,
                       input logic pe);
        @(posedge clk);
        bb_rx_pkt         <= 1'b1;
        bb_rx_crc_ok      <= c;
        bb_rx_repeat      <= r;
        bb_rx_pipe        <= p;
        bb_ack_payload_en <= pe;
        @(posedge clk);
        bb_rx_pkt <= 1'b0;
        #1 q = {4'h0, bb_send_ack, bb_ack_with_payload, rx_store, irq};
    endtask
    task automatic conclude();
        $display("mismatches %0d of %0d compares", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        conclude();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_n, reg_wr, reg_rd, txw_start, txw_ack_payload, txw_retry} = '0;
        {txw_byte, txw_end, tx_flush, rx_read_done, rx_flush} = '0;
        {bb_rx_pkt, bb_rx_crc_ok, bb_rx_repeat, bb_ack_payload_en} = '0;
        {stall, listen, lose_ack, reg_addr, reg_wdata, txw_pipe} = '0;
        bb_rx_pipe = 3'h0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        foreach (ROWS[k]) begin
            rw(ROWS[k].w, ROWS[k].a, ROWS[k].d, q);
            if (!ROWS[k].w) check(q, ROWS[k].e, "register");
        end
        // Both layouts: fill while the peer stalls, overflow, then drain.
        for (int lay = 0; lay < 2; lay++) begin
            nb = lay ? 6 : 3;
            bs = lay ? 16 : 32;
            rw(1'b1, OFF_TX_LAYOUT, lay ? 8'h40 : 8'h00, q);
            @(posedge clk);
            stall <= 1'b1;
            r0 = req_cnt;
            a0 = ab_cnt;
            repeat (nb) txw(bs, 1'b0, 1'b0, 3'h1);
            stat(SEL_FULL, 8'h02);
            stat(SEL_NOT_FULL, 8'h00);
            txw(1, 1'b0, 1'b0, 3'h1);
            check(8'(ab_cnt - a0), 8'h01, "abort when full");
            stall <= 1'b0;
            repeat (120) @(posedge clk);
            txw(bs + 1, 1'b0, 1'b0, 3'h1);
            check(8'(ab_cnt - a0), 8'h02, "abort oversize");
            check(8'(req_cnt - r0), 8'(nb), "sends");
            stat(SEL_EMPTY, 8'h02);
        end
        // One lost acknowledgement, then a sequence that never succeeds.
        rw(1'b1, OFF_TX_LAYOUT, 8'h00, q);
        rw(1'b1, OFF_RETRY, 8'h31, q);
        rw(1'b1, OFF_RESEND, 8'h20, q);
        for (int miss = 0; miss < 2; miss++) begin
            @(posedge clk);
            listen   <= 1'b1;
            lose_ack <= 1'b1;
            {r0, i0, a0} = {req_cnt, irq_cnt, to_cnt};
            txw(4, 1'b0, 1'b1, 3'h1);
            for (wt = 0; wt < 100 && to_cnt == a0; wt++) @(posedge clk);
            lose_ack <= miss[0];
            stat(SEL_NOT_EMPTY, 8'h02);
            repeat (250) @(posedge clk);
            check(8'(req_cnt - r0), miss ? 8'h03 : 8'h02, "sends");
            check(8'(irq_cnt - i0), miss ? 8'h00 : 8'h01, "irq");
            stat(SEL_EMPTY, 8'h02);
        end
        listen   <= 1'b0;
        lose_ack <= 1'b0;
        rxp(1'b1, 1'b0, 3'h1, 1'b0);
        check(q, 8'h0b, "new packet");
        stat(SEL_EMPTY, 8'h03);
        rxp(1'b1, 1'b1, 3'h1, 1'b0);
        check(q, 8'h08, "repeat packet");
        rxp(1'b0, 1'b0, 3'h1, 1'b0);
        check(q, 8'h00, "bad packet");
        repeat (2) rxp(1'b1, 1'b0, 3'h1, 1'b0);
        check(q, 8'h0b, "third block");
        rxp(1'b1, 1'b0, 3'h1, 1'b0);
        check(q, 8'h00, "receive when full");
        repeat (3) begin
            @(posedge clk);
            rx_read_done <= 1'b1;
            @(posedge clk);
            rx_read_done <= 1'b0;
        end
        stat(SEL_EMPTY, 8'h02);
        r0 = req_cnt;
        txw(3, 1'b1, 1'b0, 3'h2);
        check(8'(req_cnt - r0), 8'h00, "payload sent alone");
        rxp(1'b1, 1'b0, 3'h1, 1'b1);
        check(q, 8'h0b, "other pipe");
        stat(SEL_NOT_EMPTY, 8'h03);
        rxp(1'b1, 1'b0, 3'h2, 1'b1);
        check(q, 8'h0f, "ack with payload");
        stat(SEL_EMPTY, 8'h03);
        @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        rw(1'b0, OFF_STATUS, 8'h00, q);
        check(q, 8'h02, "status after reset");
        conclude();
    end
endmodule
bind rpf_ctrl rpf_ctrl_props #(.STEP(STEP)) props_u (.clk, .rst_n,
    .txw_abort, .bb_ack_seen, .bb_ack_timeout, .bb_rx_pkt, .bb_rx_crc_ok,
    .bb_rx_repeat, .bb_send_req, .bb_send_ack, .bb_ack_with_payload,
    .rx_store, .irq);
